// ### rtl/fic_pkg.sv
// Constants and types for the FIFO level and receive configuration block
package fic_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFF_INT_FLAGS    = 8'h58;
  localparam logic [7:0]  OFF_INT_EN       = 8'h5C;
  localparam logic [7:0]  OFF_BYTE_TEST    = 8'h64;
  localparam logic [7:0]  OFF_FIFO_LVL     = 8'h68;
  localparam logic [7:0]  OFF_RX_CFG       = 8'h6C;
  localparam logic [7:0]  OFF_INT_CLEAR    = 8'h80;

  // Fixed byte order pattern
  localparam logic [31:0] BYTE_TEST_VALUE  = 32'h87654321;

  // Interrupt flag positions
  localparam int          IRQ_RX_DONE_BIT  = 20;
  localparam int          IRQ_TX_SPACE_BIT = 9;
  localparam int          IRQ_TX_STS_BIT   = 7;
  localparam int          IRQ_RX_STS_BIT   = 3;
  localparam logic [31:0] IRQ_MASK         = 32'h00100288;
  localparam logic [31:0] IRQ_RST          = 32'h00000000;

  // Level threshold fields
  localparam int          THR_W            = 8;
  localparam int          TX_SPACE_LSB     = 24;
  localparam int          TX_STS_LSB       = 16;
  localparam int          RX_STS_LSB       = 0;
  localparam logic [7:0]  TX_SPACE_RST     = 8'h48;
  localparam logic [7:0]  TX_STS_RST       = 8'h00;
  localparam logic [7:0]  RX_STS_RST       = 8'h00;

  // Receive configuration fields
  localparam int          ALIGN_LSB        = 30;
  localparam int          CNT_LSB          = 16;
  localparam int          CNT_W            = 12;
  localparam int          FLUSH_BIT        = 15;
  localparam int          OFFSET_LSB       = 8;
  localparam int          OFFSET_W         = 5;
  localparam logic [1:0]  ALIGN_RST        = 2'b00;
  localparam logic [11:0] CNT_RST          = 12'h000;
  localparam logic [4:0]  OFFSET_RST       = 5'h00;

  // End alignment encodings
  typedef enum logic [1:0] {
    ALIGN_4    = 2'b00,
    ALIGN_16   = 2'b01,
    ALIGN_32   = 2'b10,
    ALIGN_RSVD = 2'b11
  } fic_align_t;

  // Receive read sequencer states
  typedef enum logic [1:0] {
    SEQ_LEAD = 2'b00,
    SEQ_DATA = 2'b01,
    SEQ_PAD  = 2'b10
  } fic_seq_state_t;

endpackage

// ### rtl/fic_rx_seq_if.sv
// Signals between the register bank and the receive read sequencer
`timescale 1ns/1ps
`default_nettype none
interface fic_rx_seq_if;
  logic                pop;
  logic                last;
  logic                flush;
  fic_pkg::fic_align_t align;
  logic [2:0]          offset_dw;
  logic                fifo_pop;
  logic                pad_read;

  modport ctl (output pop, output last, output flush, output align, output offset_dw,
               input fifo_pop, input pad_read);
  modport seq (input pop, input last, input flush, input align, input offset_dw,
               output fifo_pop, output pad_read);
endinterface
`default_nettype wire

// ### rtl/fic_rx_seq.sv
// Receive read sequencer: leading offset dwords, data, end padding dwords
`timescale 1ns/1ps
`default_nettype none
module fic_rx_seq
  import fic_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control side
  fic_rx_seq_if.seq sq
);

  fic_seq_state_t state_q;
  logic [2:0]     lead_q;
  logic [2:0]     pos_q;
  logic [2:0]     pad_q;
  logic [2:0]     mask;
  logic [2:0]     pos_nx;
  logic [2:0]     rem;
  logic [2:0]     pad_need;
  logic           data_rd;

  always_comb begin
    unique case (sq.align)
      ALIGN_16: mask = 3'd3;
      ALIGN_32: mask = 3'd7;
      default:  mask = 3'd0;
    endcase
  end

  // Upper offset bits are looked at live on each read
  assign data_rd     = (state_q == SEQ_DATA) || ((state_q == SEQ_LEAD) && (lead_q >= sq.offset_dw));
  assign sq.fifo_pop = sq.pop & data_rd;
  assign sq.pad_read = sq.pop & ~data_rd;
  assign pos_nx      = pos_q + 3'd1;
  assign rem         = pos_nx & mask;
  assign pad_need    = (rem == 3'd0) ? 3'd0 : 3'(mask - rem + 3'd1);

  // Packet phase
  always_ff @(posedge clk_sys) begin
    if (rst || sq.flush) begin
      state_q <= SEQ_LEAD;
      pad_q   <= 3'd0;
    end else if (sq.pop) begin
      unique case (state_q)
        SEQ_LEAD, SEQ_DATA: begin
          if (data_rd && sq.last) begin
            state_q <= (pad_need != 3'd0) ? SEQ_PAD : SEQ_LEAD;
            pad_q   <= pad_need;
          end else if (data_rd) begin
            state_q <= SEQ_DATA;
          end
        end
        SEQ_PAD: begin
          pad_q <= pad_q - 3'd1;
          if (pad_q == 3'd1) begin
            state_q <= SEQ_LEAD;
          end
        end
        default: state_q <= SEQ_LEAD;
      endcase
    end
  end

  // Position within the packet and leading dword count
  always_ff @(posedge clk_sys) begin
    if (rst || sq.flush) begin
      lead_q <= 3'd0;
      pos_q  <= 3'd0;
    end else if (sq.pop) begin
      if ((state_q == SEQ_PAD && pad_q == 3'd1) || (data_rd && sq.last && pad_need == 3'd0)) begin
        lead_q <= 3'd0;
        pos_q  <= 3'd0;
      end else begin
        pos_q <= pos_nx;
        if (!data_rd) begin
          lead_q <= lead_q + 3'd1;
        end
      end
    end
  end

endmodule // fic_rx_seq
`default_nettype wire

// ### rtl/fic_fifo_level_rx_cfg.sv
// APB register bank for FIFO level interrupts and receive configuration
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - A read-only word always returns 87654321h for byte order detection.
// - Transmit data space flag sets while free 64-byte blocks exceed threshold.
// - Transmit status flag sets while status FIFO occupancy exceeds its threshold.
// - Receive status flag sets while status FIFO occupancy exceeds its threshold.
// - Final receive transfer is padded with dwords up to 4, 16 or 32 bytes.
// - Twelve-bit dword count sets transfer-done flag when fully read out.
// - Count falls by one for each dword the host reads.
// - A host write replaces the running count at any time.
// - Writing one to flush bit empties receive data and status FIFOs.
// - A byte offset of 0 to 31 is inserted before each packet.
// - Upper offset bits may change live, acting from the next dword read.
// - Transfer-done has its own flag and enable bit gating the request.
// - Level flags are write-one-to-clear flag bits resetting to zero.
// - Flags follow sources regardless of enables; enabled flags drive interrupt.
module fic_fifo_level_rx_cfg
  import fic_pkg::*;
#(
  parameter int LEVEL_W = 8
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // APB slave
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  // FIFO levels
  input  wire logic [LEVEL_W-1:0] tx_data_free_blocks,
  input  wire logic [LEVEL_W-1:0] tx_status_used,
  input  wire logic [LEVEL_W-1:0] rx_status_used,
  // Receive data port
  input  wire logic               rx_dword_read,
  input  wire logic               rx_dword_last,
  output var  logic               rx_fifo_pop,
  output var  logic               rx_pad_read,
  output var  logic [1:0]         rx_byte_shift,
  // Receive flush
  output var  logic               rx_flush,
  input  wire logic               rx_flush_done,
  // Interrupt
  output var  logic               irq
);

  if (LEVEL_W < THR_W) begin : g_chk
    $error("LEVEL_W must be at least 8");
  end

  // Field layout checks
  if (TX_SPACE_LSB + THR_W > 32 || TX_STS_LSB + THR_W > TX_SPACE_LSB) begin : g_chk_lvl
    $error("Threshold fields overlap or leave the word");
  end

  if (RX_STS_LSB + THR_W > TX_STS_LSB) begin : g_chk_rx_sts
    $error("Receive status threshold overlaps its neighbour");
  end

  if (ALIGN_LSB + 2 > 32 || CNT_LSB + CNT_W > ALIGN_LSB || FLUSH_BIT >= CNT_LSB) begin : g_chk_cfg
    $error("Receive count field overlaps its neighbours");
  end

  if (OFFSET_W != 5 || OFFSET_LSB + OFFSET_W > FLUSH_BIT) begin : g_chk_off
    $error("Payload offset must be five bits below the flush bit");
  end

  if (IRQ_RX_DONE_BIT > 31 || IRQ_TX_SPACE_BIT > 31 ||
      IRQ_TX_STS_BIT > 31 || IRQ_RX_STS_BIT > 31) begin : g_chk_irq
    $error("Interrupt flag positions must lie inside the word");
  end

  // Register state
  logic [THR_W-1:0]    tx_space_thr_q;
  logic [THR_W-1:0]    tx_sts_thr_q;
  logic [THR_W-1:0]    rx_sts_thr_q;
  fic_align_t          align_q;
  logic [CNT_W-1:0]    rx_transfer_countdown_q;
  logic [OFFSET_W-1:0] rx_payload_offset_q;
  logic                flush_q;
  logic                flag_rx_done_q;
  logic                flag_tx_space_q;
  logic                flag_tx_sts_q;
  logic                flag_rx_sts_q;
  logic                flag_rx_done_d;
  logic                flag_tx_space_d;
  logic                flag_tx_sts_d;
  logic                flag_rx_sts_d;
  logic [31:0]         interrupt_flags;
  logic [31:0]         interrupt_flags_d;
  logic [31:0]         irq_en_q;
  logic [31:0]         prdata_q;
  logic                irq_q;

  // Bus decode
  logic                access;
  logic                setup;
  logic                hit;
  logic                wr;
  logic                wr_flags;
  logic                wr_en;
  logic                wr_lvl;
  logic                wr_cfg;
  logic                wr_clear;
  logic                sel_flags;
  logic                sel_en;
  logic                sel_test;
  logic                sel_lvl;
  logic                sel_cfg;
  logic                sel_clear;
  logic [31:0]         rd_word;

  // Events
  logic                rx_done_evt;
  logic [31:0]         set_vec;
  logic [31:0]         clr_vec;

  fic_rx_seq_if sq ();

  // Register selects
  assign sel_flags = (paddr == OFF_INT_FLAGS);
  assign sel_en    = (paddr == OFF_INT_EN);
  assign sel_test  = (paddr == OFF_BYTE_TEST);
  assign sel_lvl   = (paddr == OFF_FIFO_LVL);
  assign sel_cfg   = (paddr == OFF_RX_CFG);
  assign sel_clear = (paddr == OFF_INT_CLEAR);

  assign access   = psel & penable;
  assign setup    = psel & ~penable;
  assign hit      = sel_flags | sel_en | sel_test | sel_lvl | sel_cfg | sel_clear;
  assign wr       = access & pwrite;
  assign wr_flags = wr & sel_flags;
  assign wr_en    = wr & sel_en;
  assign wr_lvl   = wr & sel_lvl;
  assign wr_cfg   = wr & sel_cfg;
  assign wr_clear = wr & sel_clear;

  // Zero wait states; unmapped addresses answer with an error
  assign pready   = 1'b1;
  assign pslverr  = access & ~hit;
  assign prdata   = prdata_q;

  // Read mux, reserved fields zero
  always_comb begin
    rd_word = 32'h00000000;
    unique case (paddr)
      OFF_INT_FLAGS: rd_word = interrupt_flags;
      OFF_INT_EN:    rd_word = irq_en_q;
      OFF_BYTE_TEST: rd_word = BYTE_TEST_VALUE;
      OFF_FIFO_LVL: begin
        rd_word[TX_SPACE_LSB +: THR_W] = tx_space_thr_q;
        rd_word[TX_STS_LSB +: THR_W]   = tx_sts_thr_q;
        rd_word[RX_STS_LSB +: THR_W]   = rx_sts_thr_q;
      end
      OFF_RX_CFG: begin
        rd_word[ALIGN_LSB +: 2]         = align_q;
        rd_word[CNT_LSB +: CNT_W]       = rx_transfer_countdown_q;
        rd_word[FLUSH_BIT]              = flush_q;
        rd_word[OFFSET_LSB +: OFFSET_W] = rx_payload_offset_q;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle, held through the access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  // Level thresholds
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_space_thr_q <= TX_SPACE_RST;
      tx_sts_thr_q   <= TX_STS_RST;
      rx_sts_thr_q   <= RX_STS_RST;
    end else if (wr_lvl) begin
      tx_space_thr_q <= pwdata[TX_SPACE_LSB +: THR_W];
      tx_sts_thr_q   <= pwdata[TX_STS_LSB +: THR_W];
      rx_sts_thr_q   <= pwdata[RX_STS_LSB +: THR_W];
    end
  end

  // End alignment and payload offset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      align_q             <= fic_align_t'(ALIGN_RST);
      rx_payload_offset_q <= OFFSET_RST;
    end else if (wr_cfg) begin
      align_q             <= fic_align_t'(pwdata[ALIGN_LSB +: 2]);
      rx_payload_offset_q <= pwdata[OFFSET_LSB +: OFFSET_W];
    end
  end

  // Transfer countdown; a write wins over a coincident read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_transfer_countdown_q <= CNT_RST;
    end else if (wr_cfg) begin
      rx_transfer_countdown_q <= pwdata[CNT_LSB +: CNT_W];
    end else if (rx_dword_read && rx_transfer_countdown_q != CNT_RST) begin
      rx_transfer_countdown_q <= rx_transfer_countdown_q - 12'h001;
    end
  end

  assign rx_done_evt = rx_dword_read && !wr_cfg && (rx_transfer_countdown_q == 12'h001);

  // Flush stays set until the FIFOs report their pointers cleared
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flush_q <= 1'b0;
    end else if (wr_cfg && pwdata[FLUSH_BIT]) begin
      flush_q <= 1'b1;
    end else if (rx_flush_done) begin
      flush_q <= 1'b0;
    end
  end

  assign rx_flush = flush_q;

  // Flag sources
  always_comb begin
    set_vec                   = 32'h00000000;
    set_vec[IRQ_RX_DONE_BIT]  = rx_done_evt;
    set_vec[IRQ_TX_SPACE_BIT] = tx_data_free_blocks > LEVEL_W'(tx_space_thr_q);
    set_vec[IRQ_TX_STS_BIT]   = tx_status_used > LEVEL_W'(tx_sts_thr_q);
    set_vec[IRQ_RX_STS_BIT]   = rx_status_used > LEVEL_W'(rx_sts_thr_q);
  end

  assign clr_vec = (wr_flags || wr_clear) ? pwdata : 32'h00000000;

  // Next flag values; set wins over clear, enables do not gate the flags
  assign flag_rx_done_d  = set_vec[IRQ_RX_DONE_BIT] |
                           (flag_rx_done_q & ~clr_vec[IRQ_RX_DONE_BIT]);
  assign flag_tx_space_d = set_vec[IRQ_TX_SPACE_BIT] |
                           (flag_tx_space_q & ~clr_vec[IRQ_TX_SPACE_BIT]);
  assign flag_tx_sts_d   = set_vec[IRQ_TX_STS_BIT] |
                           (flag_tx_sts_q & ~clr_vec[IRQ_TX_STS_BIT]);
  assign flag_rx_sts_d   = set_vec[IRQ_RX_STS_BIT] |
                           (flag_rx_sts_q & ~clr_vec[IRQ_RX_STS_BIT]);

  // Transfer-done flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_rx_done_q <= IRQ_RST[IRQ_RX_DONE_BIT];
    end else begin
      flag_rx_done_q <= flag_rx_done_d;
    end
  end

  // Transmit space flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_tx_space_q <= IRQ_RST[IRQ_TX_SPACE_BIT];
    end else begin
      flag_tx_space_q <= flag_tx_space_d;
    end
  end

  // Transmit status level flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_tx_sts_q <= IRQ_RST[IRQ_TX_STS_BIT];
    end else begin
      flag_tx_sts_q <= flag_tx_sts_d;
    end
  end

  // Receive status level flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_rx_sts_q <= IRQ_RST[IRQ_RX_STS_BIT];
    end else begin
      flag_rx_sts_q <= flag_rx_sts_d;
    end
  end

  // Flag word as read back, and its next value for the request logic
  always_comb begin
    interrupt_flags                   = IRQ_RST;
    interrupt_flags[IRQ_RX_DONE_BIT]  = flag_rx_done_q;
    interrupt_flags[IRQ_TX_SPACE_BIT] = flag_tx_space_q;
    interrupt_flags[IRQ_TX_STS_BIT]   = flag_tx_sts_q;
    interrupt_flags[IRQ_RX_STS_BIT]   = flag_rx_sts_q;
  end

  always_comb begin
    interrupt_flags_d                   = IRQ_RST;
    interrupt_flags_d[IRQ_RX_DONE_BIT]  = flag_rx_done_d;
    interrupt_flags_d[IRQ_TX_SPACE_BIT] = flag_tx_space_d;
    interrupt_flags_d[IRQ_TX_STS_BIT]   = flag_tx_sts_d;
    interrupt_flags_d[IRQ_RX_STS_BIT]   = flag_rx_sts_d;
  end

  // Interrupt enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_en_q <= IRQ_RST;
    end else if (wr_en) begin
      irq_en_q <= pwdata & IRQ_MASK;
    end
  end

  // Interrupt request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(interrupt_flags_d & irq_en_q);
    end
  end

  assign irq = irq_q;

  // Receive read sequencer
  assign sq.pop       = rx_dword_read;
  assign sq.last      = rx_dword_last;
  assign sq.flush     = flush_q;
  assign sq.align     = align_q;
  assign sq.offset_dw = rx_payload_offset_q[OFFSET_W-1:2];
  assign rx_fifo_pop  = sq.fifo_pop;
  assign rx_pad_read  = sq.pad_read;
  assign rx_byte_shift = rx_payload_offset_q[1:0];

  fic_rx_seq u_seq (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sq      (sq.seq)
  );

endmodule // fic_fifo_level_rx_cfg
`default_nettype wire

// ### testbench/fic_sva.sv
// Port assertions for the FIFO level and receive configuration bank
`timescale 1ns/1ps
`default_nettype none
module fic_sva
  import fic_pkg::*;
#(
  parameter int LEVEL_W = 8
) (
  // Clock, reset and APB
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic [7:0]         paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Levels, receive port, interrupt
  input wire logic [LEVEL_W-1:0] tx_data_free_blocks,
  input wire logic [LEVEL_W-1:0] tx_status_used,
  input wire logic [LEVEL_W-1:0] rx_status_used,
  input wire logic               rx_dword_read,
  input wire logic               rx_dword_last,
  input wire logic               rx_fifo_pop,
  input wire logic               rx_pad_read,
  input wire logic [1:0]         rx_byte_shift,
  input wire logic               rx_flush,
  input wire logic               rx_flush_done,
  input wire logic               irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       acc;
  logic       wr_cfg;
  logic       mapped;
  logic [1:0] wshift;
  assign acc    = psel && penable;
  assign wr_cfg = acc && pwrite && paddr == OFF_RX_CFG;
  assign wshift = pwdata[9:8];
  assign mapped = paddr inside {OFF_INT_FLAGS, OFF_INT_EN, OFF_BYTE_TEST, OFF_FIFO_LVL,
                                OFF_RX_CFG, OFF_INT_CLEAR};
  a_byte_test: assert property (psel && !penable && !pwrite && paddr == OFF_BYTE_TEST
    |=> prdata == BYTE_TEST_VALUE) else $error("byte test word wrong");
  a_flush_start: assert property (wr_cfg && pwdata[FLUSH_BIT] |=> rx_flush)
    else $error("flush not started");
  a_flush_hold: assert property (rx_flush && !rx_flush_done |=> rx_flush)
    else $error("flush dropped early");
  a_flush_end: assert property (rx_flush && rx_flush_done && !wr_cfg |=> !rx_flush)
    else $error("flush did not end");
  a_read_route: assert property (rx_dword_read |-> rx_fifo_pop != rx_pad_read)
    else $error("read not routed once");
  a_no_stray: assert property (!rx_dword_read |-> !rx_fifo_pop && !rx_pad_read)
    else $error("pop without read");
  a_shift_load: assert property (wr_cfg |=> rx_byte_shift == $past(wshift))
    else $error("byte shift not loaded");
  a_err_map: assert property (acc |-> pslverr == !mapped)
    else $error("error response wrong");
  a_irq_reset: assert property ($fell(rst) |-> !irq)
    else $error("irq high after reset");
  c_pad: cover property (rx_pad_read);
  c_flush: cover property (rx_flush && rx_flush_done);
  c_irq: cover property ($rose(irq));
endmodule // fic_sva
`default_nettype wire

// ### testbench/fic_host_model.sv
// Host model: APB master and receive data port reader
`timescale 1ns/1ps
`default_nettype none
module fic_host_model (
  // Clock
  input  wire logic        clk_sys,
  // APB master
  output var  logic [7:0]  paddr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Receive port and wait status
  output var  logic        rx_dword_read,
  output var  logic        rx_dword_last,
  input  wire logic        rx_fifo_pop,
  input  wire logic        rx_pad_read,
  output var  logic        hung
);
  initial {paddr, psel, penable, pwrite, pwdata, rx_dword_read, rx_dword_last, hung} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    hung = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Padding reads are flagged so the caller drops them
  task automatic pull(input logic last, output logic pad, output logic pop);
    @(posedge clk_sys);
    rx_dword_read <= 1'b1;
    rx_dword_last <= last;
    #1;
    pad = rx_pad_read;
    pop = rx_fifo_pop;
    @(posedge clk_sys);
    rx_dword_read <= 1'b0;
    rx_dword_last <= 1'b0;
  endtask
endmodule // fic_host_model
`default_nettype wire

// ### testbench/fic_fifo_level_rx_cfg_tb.sv
// Self-checking bench for the FIFO level and receive configuration bank
`timescale 1ns/1ps
`default_nettype none
module fic_fifo_level_rx_cfg_tb;
  import fic_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr, tx_data_free_blocks, tx_status_used, rx_status_used;
  logic [31:0] pwdata, prdata;
  logic [1:0]  rx_byte_shift;
  logic        psel, penable, pwrite, pready, pslverr, irq, hung, perr;
  logic        rx_dword_read, rx_dword_last, rx_fifo_pop, rx_pad_read, rx_flush, rx_flush_done;
  int          bad_count = 0;
  int          num_checks = 0;
  fic_fifo_level_rx_cfg #(.LEVEL_W(8)) DUT (.*);
  fic_host_model u_host (.*);
  always #2.5 clk_sys = ~clk_sys;
  task automatic stop_test;
    if (u_host.hung) bad_count++;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q, perr);
    if (u_host.hung) stop_test();
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q, perr);
    if (u_host.hung) stop_test();
    chk(nm, q, exp);
  endtask
  task automatic flush_done;
    @(posedge clk_sys);
    rx_flush_done <= 1'b1;
    @(posedge clk_sys);
    rx_flush_done <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_regs;
    rc("byte_test", OFF_BYTE_TEST, BYTE_TEST_VALUE);
    rc("lvl_rst", OFF_FIFO_LVL, 32'h48000000);
    rc("cfg_rst", OFF_RX_CFG, 32'h0);
    rc("flag_rst", OFF_INT_FLAGS, 32'h0);
    wr(OFF_BYTE_TEST, 32'h0);
    rc("byte_test_wr", OFF_BYTE_TEST, BYTE_TEST_VALUE);
    wr(OFF_FIFO_LVL, 32'hFFFFFFFF);
    rc("lvl_rsvd", OFF_FIFO_LVL, 32'hFFFF00FF);
    wr(OFF_RX_CFG, 32'hFFFF7FFF);
    rc("cfg_rsvd", OFF_RX_CFG, 32'hCFFF1F00);
    wr(OFF_RX_CFG, 32'h0);
    rc("clear_rd", OFF_INT_CLEAR, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    chk("unmapped_err", perr, 32'h1);
  endtask
  task automatic t_levels;
    logic [31:0] bm [3];
    int i;
    bm = '{32'h200, 32'h80, 32'h8};
    wr(OFF_FIFO_LVL, 32'h05050005);
    for (i = 0; i < 3; i++) begin
      wr(OFF_INT_EN, IRQ_MASK);
      for (int v = 5; v < 7; v++) begin
        @(posedge clk_sys);
        if (i == 0) tx_data_free_blocks <= 8'(v);
        else if (i == 1) tx_status_used <= 8'(v);
        else rx_status_used <= 8'(v);
        rc("flag_lvl", OFF_INT_FLAGS, (v == 6) ? bm[i] : 32'h0);
        chk("irq_lvl", irq, (v == 6) ? 32'h1 : 32'h0);
      end
      wr(OFF_INT_EN, 32'h0);
      @(posedge clk_sys);
      #1;
      chk("irq_masked", irq, 32'h0);
      rc("flag_masked", OFF_INT_FLAGS, bm[i]);
      {tx_data_free_blocks, tx_status_used, rx_status_used} <= '0;
      wr(OFF_INT_FLAGS, bm[i]);
      rc("flag_w1c", OFF_INT_FLAGS, 32'h0);
    end
  endtask
  task automatic t_count;
    logic pad, pop;
    wr(OFF_INT_EN, 32'h00100000);
    wr(OFF_RX_CFG, 32'h00030000);
    repeat (2) u_host.pull(1'b0, pad, pop);
    rc("cnt_left", OFF_RX_CFG, 32'h00010000);
    wr(OFF_RX_CFG, 32'h00020000);
    u_host.pull(1'b0, pad, pop);
    rc("cnt_reload", OFF_INT_FLAGS, 32'h0);
    u_host.pull(1'b0, pad, pop);
    rc("done_flag", OFF_INT_FLAGS, 32'h00100000);
    chk("done_irq", irq, 32'h1);
    wr(OFF_INT_CLEAR, IRQ_MASK);
    rc("done_clr", OFF_INT_FLAGS, 32'h0);
  endtask
  task automatic t_flush;
    wr(OFF_RX_CFG, 32'h00008000);
    #1;
    chk("flush_out", rx_flush, 32'h1);
    rc("flush_bit", OFF_RX_CFG, 32'h00008000);
    flush_done();
    chk("flush_end", rx_flush, 32'h0);
    rc("flush_clr", OFF_RX_CFG, 32'h0);
  endtask
  task automatic t_packets;
    int a, k, lead, blk, padn;
    logic [31:0] cfg, ex;
    logic pad, pop;
    for (a = 0; a < 4; a++) begin
      cfg  = (32'(a) << ALIGN_LSB) | (32'(a * 9) << OFFSET_LSB);
      lead = (a * 9) >> 2;
      blk  = (a == 1) ? 4 : (a == 2) ? 8 : 1;
      padn = (blk - (lead + 3) % blk) % blk;
      wr(OFF_RX_CFG, (cfg & 32'hC0000300) | 32'h8000);
      flush_done();
      wr(OFF_RX_CFG, cfg);
      #1;
      chk("byte_shift", rx_byte_shift, 32'(a * 9) & 32'h3);
      for (k = 0; k < lead + 3 + padn; k++) begin
        u_host.pull(k == lead + 2, pad, pop);
        ex = (k < lead || k > lead + 2) ? 32'h2 : 32'h1;
        chk("read_kind", {30'h0, pad, pop}, ex);
      end
    end
  endtask
  initial begin
    {tx_data_free_blocks, tx_status_used, rx_status_used, rx_flush_done} = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_levels();
    t_count();
    t_flush();
    t_packets();
    stop_test();
  end
endmodule // fic_fifo_level_rx_cfg_tb
bind fic_fifo_level_rx_cfg fic_sva #(.LEVEL_W(LEVEL_W)) u_sva (.*);
`default_nettype wire
